// file: rtl/crs_consts.vh
/*
  Constants for the core register set: flag bit positions, reset values,
  widths and operation codes used by the execution port.
  Assumes it is included by its bare name from files under rtl/.
*/
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

`define CRS_DATA_W 8
`define CRS_PC_W 16
`define CRS_PMEM_BYTES 16384

`define CRS_F_GIE 0
`define CRS_F_ZERO 1
`define CRS_F_CARRY 2
`define CRS_F_SUPER 3
`define CRS_F_BANK 4
`define CRS_F_USED_MASK 8'h1f

`define CRS_F_RST 8'h02
`define CRS_A_RST 8'h00
`define CRS_X_RST 8'h00
`define CRS_SP_RST 8'h00
`define CRS_PC_RST 16'h0000

`define CRS_FOP_NONE 2'h0
`define CRS_FOP_AND 2'h1
`define CRS_FOP_OR 2'h2
`define CRS_FOP_XOR 2'h3

`endif

// file: rtl/crs_reg8.v
/*
  One 8-bit architectural register with load enable and clock enable.
  Assumes a synchronised active-low reset from the parent.
*/
`timescale 1ns/10ps
module crs_reg8 #(
  parameter [7:0] RST_VAL = 8'h00
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // Load port.
  input wire ld_i,
  input wire [7:0] d_i,
  output reg [7:0] q_o
);

  // Load only while the clock enable is high so a stalled core freezes.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RST_VAL;
    end else if (ce_i && ld_i) begin
      q_o <= d_i;
    end
  end

endmodule

// file: rtl/crs_core_regs.v
/*
  Architectural register set of an 8-bit Harvard core: program counter,
  accumulator, index, stack pointer and flags.
  Assumes the execution logic of the same core drives the write strobes,
  all synchronous to clk_i; there is no memory-mapped access.
*/
`timescale 1ns/10ps
`include "crs_consts.vh"
module crs_core_regs #(
  parameter PC_W = `CRS_PC_W,
  parameter PMEM_BYTES = `CRS_PMEM_BYTES
) (
  // Clock, reset and enable.
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  // Program counter load.
  input wire pc_inc_i,
  input wire pc_ld_i,
  input wire [15:0] pc_d_i,
  // Accumulator, index and stack pointer loads.
  input wire acc_ld_i,
  input wire [7:0] acc_d_i,
  input wire idx_ld_i,
  input wire [7:0] idx_d_i,
  input wire sp_ld_i,
  input wire [7:0] sp_d_i,
  input wire sp_push_i,
  input wire sp_pop_i,
  // Flag update from arithmetic, logic and shift results.
  input wire zero_we_i,
  input wire zero_d_i,
  input wire carry_we_i,
  input wire carry_d_i,
  // Logical instruction targeting the flags register.
  input wire [1:0] flag_op_i,
  input wire [7:0] flag_imm_i,
  // Supervisor entry and exit, driven by the core, not by user code.
  input wire super_set_i,
  input wire super_clr_i,
  // Register contents.
  output reg [15:0] program_counter_o,
  output wire [7:0] accumulator_reg_o,
  output wire [7:0] index_reg_o,
  output wire [7:0] stack_pointer_o,
  output reg [7:0] status_flags_o,
  output reg global_interrupt_enable_o,
  output reg register_bank_select_o,
  output reg [PC_W-1:0] pmem_addr_o,
  output reg [7:0] idx_offset_o
);

  localparam PA_W = 14;
  // Program memory mask as a full word so the cut to PC_W bits is explicit.
  localparam [31:0] PMEM_MASK = PMEM_BYTES - 1;

  reg rst_meta_ff;
  reg rst_sync_ff;
  reg [7:0] nxt_flags;
  reg [7:0] op_res;
  reg [15:0] nxt_pc;
  reg [7:0] nxt_sp;

  // Two-stage reset release; the async edge asserts immediately.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Program counter next value.
  always @* begin
    nxt_pc = program_counter_o;
    if (pc_ld_i) begin
      nxt_pc = pc_d_i;
    end else if (pc_inc_i) begin
      nxt_pc = program_counter_o + 16'h0001;
    end
  end

  always @(posedge clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      program_counter_o <= `CRS_PC_RST;
      pmem_addr_o <= {PC_W{1'b0}};
    end else if (ce_i) begin
      program_counter_o <= nxt_pc;
      pmem_addr_o <= nxt_pc[PC_W-1:0] & PMEM_MASK[PC_W-1:0];
    end
  end

  crs_reg8 #(.RST_VAL(`CRS_A_RST)) u_acc (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_ff),
    .ce_i(ce_i),
    .ld_i(acc_ld_i),
    .d_i(acc_d_i),
    .q_o(accumulator_reg_o)
  );

  crs_reg8 #(.RST_VAL(`CRS_X_RST)) u_idx (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_ff),
    .ce_i(ce_i),
    .ld_i(idx_ld_i),
    .d_i(idx_d_i),
    .q_o(index_reg_o)
  );

  // Index offset registered for the data address adder.
  always @(posedge clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      idx_offset_o <= 8'h00;
    end else if (ce_i) begin
      idx_offset_o <= idx_ld_i ? idx_d_i : index_reg_o;
    end
  end

  // Stack pointer next value; a direct load beats push or pop.
  always @* begin
    nxt_sp = stack_pointer_o;
    if (sp_ld_i) begin
      nxt_sp = sp_d_i;
    end else if (sp_push_i && !sp_pop_i) begin
      nxt_sp = stack_pointer_o + 8'h01;
    end else if (sp_pop_i && !sp_push_i) begin
      nxt_sp = stack_pointer_o - 8'h01;
    end
  end

  crs_reg8 #(.RST_VAL(`CRS_SP_RST)) u_sp (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_ff),
    .ce_i(ce_i),
    .ld_i(1'b1),
    .d_i(nxt_sp),
    .q_o(stack_pointer_o)
  );

  // Flags next value. Logical ops apply first, then result flags win
  // for zero and carry since they reflect the same instruction's outcome.
  always @* begin
    op_res = status_flags_o;
    case (flag_op_i)
      `CRS_FOP_AND: op_res = status_flags_o & flag_imm_i;
      `CRS_FOP_OR: op_res = status_flags_o | flag_imm_i;
      `CRS_FOP_XOR: op_res = status_flags_o ^ flag_imm_i;
      default: op_res = status_flags_o;
    endcase
    nxt_flags = op_res;
    nxt_flags[`CRS_F_SUPER] = status_flags_o[`CRS_F_SUPER];
    if (super_set_i) begin
      nxt_flags[`CRS_F_SUPER] = 1'b1;
    end else if (super_clr_i) begin
      nxt_flags[`CRS_F_SUPER] = 1'b0;
    end
    if (zero_we_i) begin
      nxt_flags[`CRS_F_ZERO] = zero_d_i;
    end
    if (carry_we_i) begin
      nxt_flags[`CRS_F_CARRY] = carry_d_i;
    end
    nxt_flags = nxt_flags & `CRS_F_USED_MASK;
  end

  // Flag register and decoded control bits, all registered.
  always @(posedge clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      status_flags_o <= `CRS_F_RST;
      global_interrupt_enable_o <= 1'b0;
      register_bank_select_o <= 1'b0;
    end else if (ce_i) begin
      status_flags_o <= nxt_flags;
      global_interrupt_enable_o <= nxt_flags[`CRS_F_GIE];
      register_bank_select_o <= nxt_flags[`CRS_F_BANK];
    end
  end

endmodule

// file: sim/crs_props.sv
/* Checker for the core register set ports.
   Assumes it is bound to crs_core_regs by name. */
`timescale 1ns/10ps
module crs_props (
  input wire clk_i, input wire nrst_i, input wire ce_i,
  input wire pc_inc_i, input wire pc_ld_i, input wire acc_ld_i,
  input wire [7:0] acc_d_i, input wire zero_we_i, input wire zero_d_i,
  input wire super_set_i, input wire super_clr_i, input wire [1:0] flag_op_i,
  input wire [15:0] program_counter_o, input wire [7:0] accumulator_reg_o,
  input wire [7:0] status_flags_o, input wire global_interrupt_enable_o,
  input wire register_bank_select_o, input wire [15:0] pmem_addr_o
);
  // All checks share one domain, so clock and reset are set once.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_acc_load: assert property (ce_i && acc_ld_i |=> accumulator_reg_o == $past(acc_d_i))
    else $error("acc load");
  chk_pc_step: assert property (ce_i && pc_inc_i && !pc_ld_i |=> program_counter_o == $past(program_counter_o) + 16'h1)
    else $error("pc step");
  chk_pmem_flat: assert property (pmem_addr_o == (program_counter_o & 16'h3fff))
    else $error("pmem addr");
  chk_zero_write: assert property (ce_i && zero_we_i |=> status_flags_o[1] == $past(zero_d_i))
    else $error("zero flag");
  chk_resv_zero: assert property (status_flags_o[7:5] == 3'h0)
    else $error("reserved bits");
  chk_super_kept: assert property (!(ce_i && (super_set_i || super_clr_i)) |=> $stable(status_flags_o[3]))
    else $error("super bit");
  chk_gie_mirror: assert property (global_interrupt_enable_o == status_flags_o[0])
    else $error("gie");
  chk_bank_mirror: assert property (register_bank_select_o == status_flags_o[4])
    else $error("bank");
  chk_freeze_off: assert property (!ce_i |=> $stable(accumulator_reg_o) && $stable(program_counter_o))
    else $error("freeze");
  // Main traffic kinds seen at least once.
  cover property (ce_i && flag_op_i == 2'h3);
  cover property (ce_i && super_set_i);
  cover property (ce_i && pc_ld_i);
endmodule

// file: sim/crs_exec_model.sv
/* Execution-side model issuing one command word a cycle.
   Assumes the bench renews the random word at each rising edge. */
`timescale 1ns/10ps
module crs_exec_model (
  input wire clk_i,
  input wire en_i,
  input wire [31:0] rnd_i,
  output reg [31:0] cmd_o = 32'h0
);
  // Launch at the falling edge so strobes are settled at the rising edge.
  // strobes and data fields together
  always @(negedge clk_i) begin
    cmd_o <= en_i ? rnd_i : 32'h0;
  end
endmodule

// file: sim/cpu_core_register_set_test.sv
/* Random self-checking bench for the core register set.
   Assumes rtl/ is on the include path. */
`timescale 1ns/10ps
module cpu_core_register_set_test;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg en = 1'b0;
  reg [31:0] lfsr = 32'h8737;
  wire [31:0] c;
  wire [15:0] pc, pm;
  wire [7:0] a, x, sp, f, xo;
  wire gie, bank;
  integer err_total = 0, n_tests = 0, m_pc = 0, m_a = 0, m_x = 0, m_sp = 0, m_f = 2, t;
  function [31:0] step(input [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial forever #5 clk_i = ~clk_i;
  crs_exec_model u_exec (.clk_i(clk_i), .en_i(en), .rnd_i(lfsr), .cmd_o(c));
  crs_core_regs u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(c[0] | c[1]), .pc_inc_i(c[2]),
    .pc_ld_i(c[3] & c[4]), .pc_d_i(c[31:16]), .acc_ld_i(c[5]), .acc_d_i(c[15:8]), .idx_ld_i(c[6]),
    .idx_d_i(c[23:16]), .sp_ld_i(c[7] & c[8]), .sp_d_i(c[31:24]), .sp_push_i(c[9]), .sp_pop_i(c[10]),
    .zero_we_i(c[11]), .zero_d_i(c[12]), .carry_we_i(c[13]), .carry_d_i(c[14]), .flag_op_i(c[16:15]),
    .flag_imm_i(c[31:24]), .super_set_i(c[17] & c[18] & c[19]), .super_clr_i(c[20] & c[21]),
    .program_counter_o(pc), .accumulator_reg_o(a), .index_reg_o(x), .stack_pointer_o(sp),
    .status_flags_o(f), .global_interrupt_enable_o(gie), .register_bank_select_o(bank),
    .pmem_addr_o(pm), .idx_offset_o(xo));
  // Reference model; flag ops may only touch bits 0, 1, 2 and 4.
  always @(posedge clk_i) begin
    lfsr <= step(lfsr);
    if (c[0] | c[1]) begin
      m_pc = c[3] & c[4] ? c[31:16] : (m_pc + c[2]) % 65536;
      m_a = c[5] ? c[15:8] : m_a;
      m_x = c[6] ? c[23:16] : m_x;
      m_sp = c[7] & c[8] ? c[31:24] : (m_sp + c[9] - c[10] + 256) % 256;
      t = c[16:15] == 1 ? m_f & c[31:24] : c[16:15] == 2 ? m_f | c[31:24] : c[16:15] == 3 ? m_f ^ c[31:24] : m_f;
      m_f = t & 8'h17 | m_f & 8'h08;
      if (c[11]) m_f[1] = c[12];
      if (c[13]) m_f[2] = c[14];
      if (c[17] & c[18] & c[19]) m_f[3] = 1'b1;
      else if (c[20] & c[21]) m_f[3] = 1'b0;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Outputs are settled half a cycle after the launching edge.
  always @(negedge clk_i) begin
    if (nrst_i) begin
      chk("pc", m_pc, pc);
      chk("pmem", m_pc % 16384, pm);
      chk("acc", m_a, a);
      chk("idx", m_x, x);
      chk("offset", m_x, xo);
      chk("sp", m_sp, sp);
      chk("flags", m_f, f);
      chk("gie", m_f[0], gie);
      chk("bank", m_f[4], bank);
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence, then a watchdog sized to it.
  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    en <= 1'b1;
    repeat (3000) @(negedge clk_i);
    end_of_test;
  end
  initial begin
    #40000;
    err_total = err_total + 1;
    end_of_test;
  end
endmodule
bind crs_core_regs crs_props u_props (.*);
